// [pcc_pkg.sv]
// Constants, register map and types for the port current and charge register bank
package pcc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PORT_CURRENT_READING = 8'h00;
  localparam logic [7:0] ADDR_CHARGE_TOTAL_BYTE3 = 8'h01;
  localparam logic [7:0] ADDR_CHARGE_TOTAL_BYTE2 = 8'h02;
  localparam logic [7:0] ADDR_CHARGE_TOTAL_BYTE1 = 8'h03;
  localparam logic [7:0] ADDR_CHARGE_TOTAL_BYTE0 = 8'h04;
  localparam logic [7:0] ADDR_MISC_PIN_STATE = 8'h0F;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_GENERAL_CONDITION = 8'h11;
  localparam logic [7:0] ADDR_PROFILE_STATE_A = 8'h12;
  localparam logic [7:0] ADDR_PROFILE_STATE_B = 8'h13;
  localparam logic [7:0] ADDR_PIN_LEVELS = 8'h14;
  localparam logic [7:0] ADDR_CUSTOM_STEP3_TIMING = 8'h49;
  localparam logic [7:0] ADDR_CUSTOM_STEP3_RESPONSE = 8'h4A;
  localparam logic [7:0] ADDR_CUSTOM_STEP3_THRESHOLD = 8'h4B;
  localparam logic [7:0] ADDR_CUSTOM_STEP3_RATIO = 8'h4C;
  localparam logic [7:0] ADDR_ACTIVE_LIMIT_BEHAVIOUR = 8'h50;
  localparam logic [7:0] ADDR_CUSTOM_LIMIT_BEHAVIOUR = 8'h51;
  localparam logic [7:0] ADDR_PART_IDENTIFIER = 8'hFD;
  localparam logic [7:0] ADDR_MAKER_IDENTIFIER = 8'hFE;
  localparam logic [7:0] ADDR_SILICON_REVISION = 8'hFF;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LIMIT_BEHAVIOUR = 8'h82;

  // Identity values, arbitrary neutral codes
  localparam logic [7:0] PART_ID_VAL = 8'h11;
  localparam logic [7:0] MAKER_ID_VAL = 8'h22;
  localparam logic [7:0] REVISION_VAL = 8'h01;

  // Field layout of the charge group
  localparam int ACC_W = 26;
  localparam int ACC_LSB_POS = 6;
  localparam logic [ACC_W-1:0] ACC_MAX = 26'h3FFFFFF;
  localparam int THRESH_W = 16;

  // Event flag bit positions
  localparam int EVT_ERROR_POS = 0;
  localparam int EVT_ATTACH_POS = 1;
  localparam int EVT_REMOVAL_POS = 2;

  // Timing: one charge update per second at a 20 MHz clock
  localparam longint CLK_HZ = 20000000;
  localparam longint UPDATE_PERIOD_MS = 1000;
  localparam longint UPDATE_CYCLES = (CLK_HZ * UPDATE_PERIOD_MS) / 1000;

  // Power states of the controller
  typedef enum logic [1:0] {
    PWR_SLEEP,
    PWR_DETECT,
    PWR_ACTIVE,
    PWR_ERROR
  } pcc_pwr_t;

endpackage

// [pcc_regbank.sv]
// Port current and accumulated charge register bank of a USB port power controller
`timescale 1ns/100ps
module pcc_regbank
  import pcc_pkg::*;
#(
  parameter longint CYCLES_PER_UPDATE = UPDATE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Power path state
  input wire pcc_pwr_t pwr_state,
  input wire logic switch_on,
  input wire logic [7:0] current_sample,
  input wire logic current_sample_valid,
  // Charge rationing control
  input wire logic rationing_enable_bit,
  input wire logic rationing_reset_bit,
  input wire logic [THRESH_W-1:0] rationing_threshold,
  output logic rationing_reached,
  // Status sources
  input wire logic error_event,
  input wire logic attach_event,
  input wire logic removal_event,
  input wire logic [7:0] misc_pin_state_in,
  input wire logic [7:0] general_condition_in,
  input wire logic [7:0] profile_state_a_in,
  input wire logic [7:0] profile_state_b_in,
  input wire logic [7:0] pin_levels_in,
  input wire logic [7:0] active_limit_in,
  // Host programmed settings
  output logic [7:0] custom_step3_timing,
  output logic [7:0] custom_step3_response,
  output logic [7:0] custom_step3_threshold,
  output logic [7:0] custom_step3_ratio,
  output logic [7:0] custom_limit_behaviour
);

  // Address is one the map defines
  function automatic logic is_defined(input logic [7:0] a);
    unique case (a)
      ADDR_PORT_CURRENT_READING, ADDR_CHARGE_TOTAL_BYTE3, ADDR_CHARGE_TOTAL_BYTE2,
      ADDR_CHARGE_TOTAL_BYTE1, ADDR_CHARGE_TOTAL_BYTE0, ADDR_MISC_PIN_STATE,
      ADDR_EVENT_FLAGS, ADDR_GENERAL_CONDITION, ADDR_PROFILE_STATE_A,
      ADDR_PROFILE_STATE_B, ADDR_PIN_LEVELS, ADDR_CUSTOM_STEP3_TIMING,
      ADDR_CUSTOM_STEP3_RESPONSE, ADDR_CUSTOM_STEP3_THRESHOLD, ADDR_CUSTOM_STEP3_RATIO,
      ADDR_ACTIVE_LIMIT_BEHAVIOUR, ADDR_CUSTOM_LIMIT_BEHAVIOUR, ADDR_PART_IDENTIFIER,
      ADDR_MAKER_IDENTIFIER, ADDR_SILICON_REVISION: is_defined = 1'b1;
      default: is_defined = 1'b0;
    endcase
  endfunction

  // Host write strobe to one defined address
  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] target);
    wr_hit = wr && is_defined(a) && (a == target);
  endfunction

  // Register state
  logic [7:0] current_q, current_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [31:0] tick_q, tick_d;
  logic reached_q, reached_d;
  logic [7:0] events_q, events_d;
  logic [7:0] active_limit_q, active_limit_d;
  logic [7:0] step_timing_q, step_timing_d;
  logic [7:0] step_response_q, step_response_d;
  logic [7:0] step_threshold_q, step_threshold_d;
  logic [7:0] step_ratio_q, step_ratio_d;
  logic [7:0] limit_q, limit_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] charge_word;
  logic tick;
  logic [ACC_W:0] acc_sum;

  // Charge group as one word, MSB byte at the lowest address
  assign charge_word = {acc_q, 6'h00};
  assign tick = (pwr_state == PWR_ACTIVE) && (tick_q == 32'(CYCLES_PER_UPDATE - 1));
  assign acc_sum = {1'b0, acc_q} + {19'h00000, current_q};

  // Port current reading
  always_comb begin
    current_d = current_q;
    if (pwr_state == PWR_SLEEP || pwr_state == PWR_DETECT) begin
      current_d = RST_ZERO;
    end else if (!switch_on) begin
      current_d = RST_ZERO;
    end else if (pwr_state == PWR_ACTIVE && current_sample_valid) begin
      current_d = current_sample;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      current_q <= RST_ZERO;
    end else begin
      current_q <= current_d;
    end
  end

  // One second update timer and charge accumulator
  always_comb begin
    tick_d = tick_q;
    acc_d = acc_q;
    reached_d = reached_q;
    if (pwr_state != PWR_ACTIVE || tick) begin
      tick_d = 32'h00000000;
    end else begin
      tick_d = tick_q + 32'h00000001;
    end
    if (rationing_reset_bit || !rationing_enable_bit) begin
      acc_d = '0;
      reached_d = 1'b0;
    end else if (tick) begin
      // Each second adds the current code; 11.72 mA for 1 s is one charge step
      acc_d = acc_sum[ACC_W] ? ACC_MAX : acc_sum[ACC_W-1:0];
      reached_d = (acc_d[ACC_W-1 -: THRESH_W] >= rationing_threshold);
    end
    // Otherwise the total is held, also while out of Active state
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_q <= 32'h00000000;
      acc_q <= '0;
      reached_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      acc_q <= acc_d;
      reached_q <= reached_d;
    end
  end

  // Event flags: hardware sets, host writes zero to clear, set wins
  always_comb begin
    events_d = events_q;
    if (wr_hit(reg_wr, reg_addr, ADDR_EVENT_FLAGS)) begin
      events_d = events_q & reg_wdata;
    end
    events_d[EVT_ERROR_POS] = events_d[EVT_ERROR_POS] | error_event;
    events_d[EVT_ATTACH_POS] = events_d[EVT_ATTACH_POS] | attach_event;
    events_d[EVT_REMOVAL_POS] = events_d[EVT_REMOVAL_POS] | removal_event;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      events_q <= RST_ZERO;
    end else begin
      events_q <= events_d;
    end
  end

  // Host writable configuration registers, and the applied limit copied from active_limit_in
  always_comb begin
    step_timing_d = step_timing_q;
    step_response_d = step_response_q;
    step_threshold_d = step_threshold_q;
    step_ratio_d = step_ratio_q;
    limit_d = limit_q;
    active_limit_d = active_limit_in;
    if (wr_hit(reg_wr, reg_addr, ADDR_CUSTOM_STEP3_TIMING)) begin
      step_timing_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, ADDR_CUSTOM_STEP3_RESPONSE)) begin
      step_response_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, ADDR_CUSTOM_STEP3_THRESHOLD)) begin
      step_threshold_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, ADDR_CUSTOM_STEP3_RATIO)) begin
      step_ratio_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, ADDR_CUSTOM_LIMIT_BEHAVIOUR)) begin
      limit_d = reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      step_timing_q <= RST_ZERO;
      step_response_q <= RST_ZERO;
      step_threshold_q <= RST_ZERO;
      step_ratio_q <= RST_ZERO;
      limit_q <= RST_LIMIT_BEHAVIOUR;
      active_limit_q <= RST_LIMIT_BEHAVIOUR;
    end else begin
      step_timing_q <= step_timing_d;
      step_response_q <= step_response_d;
      step_threshold_q <= step_threshold_d;
      step_ratio_q <= step_ratio_d;
      limit_q <= limit_d;
      active_limit_q <= active_limit_d;
    end
  end

  // Read mux, answered one cycle after the strobe
  always_comb begin
    rvalid_d = reg_rd;
    rdata_d = RST_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PORT_CURRENT_READING: rdata_d = current_q;
        ADDR_CHARGE_TOTAL_BYTE3: rdata_d = charge_word[31:24];
        ADDR_CHARGE_TOTAL_BYTE2: rdata_d = charge_word[23:16];
        ADDR_CHARGE_TOTAL_BYTE1: rdata_d = charge_word[15:8];
        ADDR_CHARGE_TOTAL_BYTE0: rdata_d = charge_word[7:0];
        ADDR_MISC_PIN_STATE: rdata_d = misc_pin_state_in;
        ADDR_EVENT_FLAGS: rdata_d = events_q;
        ADDR_GENERAL_CONDITION: rdata_d = general_condition_in;
        ADDR_PROFILE_STATE_A: rdata_d = profile_state_a_in;
        ADDR_PROFILE_STATE_B: rdata_d = profile_state_b_in;
        ADDR_PIN_LEVELS: rdata_d = pin_levels_in;
        ADDR_CUSTOM_STEP3_TIMING: rdata_d = step_timing_q;
        ADDR_CUSTOM_STEP3_RESPONSE: rdata_d = step_response_q;
        ADDR_CUSTOM_STEP3_THRESHOLD: rdata_d = step_threshold_q;
        ADDR_CUSTOM_STEP3_RATIO: rdata_d = step_ratio_q;
        ADDR_ACTIVE_LIMIT_BEHAVIOUR: rdata_d = active_limit_q;
        ADDR_CUSTOM_LIMIT_BEHAVIOUR: rdata_d = limit_q;
        ADDR_PART_IDENTIFIER: rdata_d = PART_ID_VAL;
        ADDR_MAKER_IDENTIFIER: rdata_d = MAKER_ID_VAL;
        ADDR_SILICON_REVISION: rdata_d = REVISION_VAL;
        default: rdata_d = RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= RST_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign rationing_reached = reached_q;
  assign custom_step3_timing = step_timing_q;
  assign custom_step3_response = step_response_q;
  assign custom_step3_threshold = step_threshold_q;
  assign custom_step3_ratio = step_ratio_q;
  assign custom_limit_behaviour = limit_q;

  // Checks
  reset_defaults_a: assert property (@(posedge clk) !nrst |=>
    current_q == RST_ZERO && acc_q == '0 && limit_q == RST_LIMIT_BEHAVIOUR && events_q == RST_ZERO)
    else $error("register defaults not loaded by reset");

  undef_read_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && !is_defined(reg_addr) |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("undefined read returned nonzero");

  undef_write_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && !is_defined(reg_addr) |=> $stable(step_timing_q) && $stable(limit_q)
      && $stable(step_ratio_q) && $stable(step_response_q) && $stable(step_threshold_q))
    else $error("undefined write changed a register");

  current_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    pwr_state == PWR_ACTIVE && switch_on && current_sample_valid |=> current_q == $past(current_sample))
    else $error("current reading did not follow sample");

  current_sleep_a: assert property (@(posedge clk) disable iff (!nrst)
    (pwr_state == PWR_SLEEP || pwr_state == PWR_DETECT) |=> current_q == 8'h00)
    else $error("current reading not cleared in sleep or detect");

  current_off_a: assert property (@(posedge clk) disable iff (!nrst)
    !switch_on |=> current_q == 8'h00)
    else $error("current reading not cleared with switch off");

  charge_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (rationing_reset_bit || !rationing_enable_bit) |=> acc_q == '0 && !rationing_reached)
    else $error("charge total not cleared by rationing control");

  charge_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    pwr_state != PWR_ACTIVE && rationing_enable_bit && !rationing_reset_bit |=> $stable(acc_q))
    else $error("charge total changed outside active state");

  charge_tick_a: assert property (@(posedge clk) disable iff (!nrst)
    tick && rationing_enable_bit && !rationing_reset_bit && !acc_sum[ACC_W]
      |=> acc_q == $past(acc_sum[ACC_W-1:0]))
    else $error("charge total did not add current on update");

  charge_compare_a: assert property (@(posedge clk) disable iff (!nrst)
    tick && rationing_enable_bit && !rationing_reset_bit
      |=> rationing_reached == (acc_q[ACC_W-1 -: THRESH_W] >= $past(rationing_threshold)))
    else $error("threshold compare wrong after update");

  charge_low_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_CHARGE_TOTAL_BYTE0 |=> reg_rdata[5:0] == 6'h00)
    else $error("unimplemented charge bits read nonzero");

  charge_msb_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_CHARGE_TOTAL_BYTE3 |=> reg_rdata == $past(acc_q[ACC_W-1 -: 8]))
    else $error("most significant charge byte misplaced");

  event_set_a: assert property (@(posedge clk) disable iff (!nrst)
    attach_event |=> events_q[EVT_ATTACH_POS])
    else $error("attach event lost");

  event_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == ADDR_EVENT_FLAGS && !reg_wdata[EVT_ERROR_POS] && !error_event
      |=> !events_q[EVT_ERROR_POS])
    else $error("error flag not cleared by zero write");

  error_set_a: assert property (@(posedge clk) disable iff (!nrst)
    error_event |=> events_q[EVT_ERROR_POS])
    else $error("error event lost");

  removal_set_a: assert property (@(posedge clk) disable iff (!nrst)
    removal_event |=> events_q[EVT_REMOVAL_POS])
    else $error("removal event lost");

  charge_mid_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_CHARGE_TOTAL_BYTE1 |=> reg_rdata == $past(acc_q[9:2]))
    else $error("charge middle low byte misplaced");

endmodule

// [pcc_host_model.sv]
// Host controller model issuing register reads and writes towards the register bank
`timescale 1ns/100ps
module pcc_host_model (
  // Clock
  input wire logic clk,
  // Register port towards the device
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write strobe; in the event flags a zero in the data clears a bit, a one keeps it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
    reg_addr = ~a; // Released lines do not keep the old value
    reg_wdata = ~d;
  endtask

  // One-cycle read strobe; the answer stands in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// [port_current_charge_registers_tb_top.sv]
// Self-checking testbench of the port current and charge register bank
`timescale 1ns/100ps
module port_current_charge_registers_tb_top
  import pcc_pkg::*;
;
  logic clk, nrst, reg_wr, reg_rd, reg_rvalid, switch_on, current_sample_valid;
  logic rationing_enable_bit, rationing_reset_bit, rationing_reached;
  logic error_event, attach_event, removal_event;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, current_sample, misc_in, gen_in, pa_in, pb_in, pin_in, lim_in;
  logic [7:0] c_tim, c_resp, c_thr, c_rat, c_lim;
  logic [THRESH_W-1:0] rationing_threshold;
  pcc_pwr_t pwr_state;
  int mismatches = 0;
  int checks_done = 0;

  // Clock of 50 ns period
  initial clk = 1'b0;
  always #25 clk = ~clk;

  pcc_regbank #(.CYCLES_PER_UPDATE(8)) DUT (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pwr_state(pwr_state), .switch_on(switch_on),
    .current_sample(current_sample), .current_sample_valid(current_sample_valid),
    .rationing_enable_bit(rationing_enable_bit), .rationing_reset_bit(rationing_reset_bit),
    .rationing_threshold(rationing_threshold), .rationing_reached(rationing_reached),
    .error_event(error_event), .attach_event(attach_event), .removal_event(removal_event),
    .misc_pin_state_in(misc_in), .general_condition_in(gen_in), .profile_state_a_in(pa_in),
    .profile_state_b_in(pb_in), .pin_levels_in(pin_in), .active_limit_in(lim_in),
    .custom_step3_timing(c_tim), .custom_step3_response(c_resp), .custom_step3_threshold(c_thr),
    .custom_step3_ratio(c_rat), .custom_limit_behaviour(c_lim)
  );

  pcc_host_model u_host (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  // Counts and verdict, then end of run
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Byte and bit comparisons
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", n, e, s);
    end
  endtask

  // Read one register and compare its value and answer strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk1($sformatf("rvalid at %h", a), 1'b1, v);
    chk8($sformatf("register %h", a), e, d);
  endtask

  // Read the four charge bytes, most significant at the lowest address
  task automatic chg(input logic [25:0] acc);
    logic [31:0] g;
    g = {acc, 6'h00};
    rdc(ADDR_CHARGE_TOTAL_BYTE3, g[31:24]);
    rdc(ADDR_CHARGE_TOTAL_BYTE2, g[23:16]);
    rdc(ADDR_CHARGE_TOTAL_BYTE1, g[15:8]);
    rdc(ADDR_CHARGE_TOTAL_BYTE0, g[7:0]);
  endtask

  // Wait whole cycles, ending just after an edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Hang guard well beyond the expected run
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    results();
  end

  // Main sequence
  initial begin
    logic [7:0] zr[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h49, 8'h4A, 8'h4B, 8'h4C};
    logic [7:0] sa[5] = '{8'h0F, 8'h11, 8'h12, 8'h13, 8'h14};
    logic [7:0] sv[5] = '{8'hA5, 8'h3C, 8'h5A, 8'hC3, 8'h96};
    logic [7:0] ca[5] = '{8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h51};
    nrst = 1'b0;
    pwr_state = PWR_SLEEP;
    {switch_on, current_sample_valid, rationing_enable_bit, rationing_reset_bit} = 4'h0;
    {error_event, attach_event, removal_event} = 3'h0;
    current_sample = 8'h00;
    rationing_threshold = 16'h0001;
    {misc_in, gen_in, pa_in, pb_in, pin_in} = {8'hA5, 8'h3C, 8'h5A, 8'hC3, 8'h96};
    lim_in = 8'h82;
    cyc(8);
    nrst = 1'b1;
    // Power-on values, identity codes
    foreach (zr[i]) rdc(zr[i], 8'h00);
    rdc(ADDR_CUSTOM_LIMIT_BEHAVIOUR, RST_LIMIT_BEHAVIOUR);
    rdc(ADDR_PART_IDENTIFIER, PART_ID_VAL);
    rdc(ADDR_MAKER_IDENTIFIER, MAKER_ID_VAL);
    rdc(ADDR_SILICON_REVISION, REVISION_VAL);
    // Undefined and read-only places
    u_host.wr(8'h05, 8'hFF);
    u_host.wr(8'h52, 8'h3F);
    u_host.wr(ADDR_PORT_CURRENT_READING, 8'h77);
    rdc(8'h05, 8'h00);
    rdc(8'h52, 8'h00);
    rdc(8'h80, 8'h00);
    rdc(ADDR_PORT_CURRENT_READING, 8'h00);
    chk8("limit output", RST_LIMIT_BEHAVIOUR, c_lim);
    // Writable settings read back and reach their outputs
    foreach (ca[i]) u_host.wr(ca[i], 8'hC0 + 8'(i));
    foreach (ca[i]) rdc(ca[i], 8'hC0 + 8'(i));
    chk8("timing output", 8'hC0, c_tim);
    chk8("response output", 8'hC1, c_resp);
    chk8("threshold output", 8'hC2, c_thr);
    chk8("ratio output", 8'hC3, c_rat);
    chk8("limit output", 8'hC4, c_lim);
    // Status group and applied limit
    foreach (sa[i]) rdc(sa[i], sv[i]);
    lim_in = 8'h3D;
    rdc(ADDR_ACTIVE_LIMIT_BEHAVIOUR, 8'h3D);
    {error_event, attach_event, removal_event} = 3'h7;
    cyc(1);
    {error_event, attach_event, removal_event} = 3'h0;
    rdc(ADDR_EVENT_FLAGS, 8'h07);
    u_host.wr(ADDR_EVENT_FLAGS, 8'h05);
    rdc(ADDR_EVENT_FLAGS, 8'h05);
    // An attach event in the cycle of a clearing write wins over the clear
    fork
      u_host.wr(ADDR_EVENT_FLAGS, 8'h00);
      begin
        @(posedge clk);
        #2;
        attach_event = 1'b1;
        @(posedge clk);
        #2;
        attach_event = 1'b0;
      end
    join
    rdc(ADDR_EVENT_FLAGS, 8'h02);
    u_host.wr(ADDR_EVENT_FLAGS, 8'h00);
    rdc(ADDR_EVENT_FLAGS, 8'h00);
    // Current reading follows samples and clears
    pwr_state = PWR_ACTIVE;
    {switch_on, current_sample_valid} = 2'h3;
    current_sample = 8'hFF;
    cyc(2);
    rdc(ADDR_PORT_CURRENT_READING, 8'hFF);
    current_sample = 8'h3C;
    cyc(2);
    rdc(ADDR_PORT_CURRENT_READING, 8'h3C);
    // Outside Active the reading is not refreshed by new samples
    pwr_state = PWR_ERROR;
    current_sample = 8'h11;
    cyc(2);
    rdc(ADDR_PORT_CURRENT_READING, 8'h3C);
    pwr_state = PWR_ACTIVE;
    switch_on = 1'b0;
    cyc(2);
    rdc(ADDR_PORT_CURRENT_READING, 8'h00);
    switch_on = 1'b1;
    cyc(2);
    pwr_state = PWR_DETECT;
    cyc(2);
    rdc(ADDR_PORT_CURRENT_READING, 8'h00);
    pwr_state = PWR_ACTIVE;
    cyc(2);
    pwr_state = PWR_SLEEP;
    cyc(2);
    rdc(ADDR_PORT_CURRENT_READING, 8'h00);
    chg(26'h0);
    // Charge: three ticks, hold, three more, threshold compare
    rationing_enable_bit = 1'b1;
    current_sample = 8'hFF;
    pwr_state = PWR_ACTIVE;
    cyc(28);
    pwr_state = PWR_DETECT;
    cyc(2);
    chg(26'h2FD);
    chk1("reached", 1'b0, rationing_reached);
    pwr_state = PWR_ACTIVE;
    cyc(28);
    pwr_state = PWR_DETECT;
    cyc(2);
    chg(26'h5FA);
    chk1("reached", 1'b1, rationing_reached);
    // Clearing by reset bit and by enable bit
    rationing_reset_bit = 1'b1;
    cyc(1);
    rationing_reset_bit = 1'b0;
    cyc(1);
    chg(26'h0);
    chk1("reached", 1'b0, rationing_reached);
    pwr_state = PWR_ACTIVE;
    cyc(12);
    pwr_state = PWR_SLEEP;
    cyc(2);
    chg(26'h0FF);
    rationing_enable_bit = 1'b0;
    cyc(1);
    rationing_enable_bit = 1'b1;
    cyc(1);
    chg(26'h0);
    results();
  end
endmodule
